// ### scp_pkg.sv
// Package: shared constants and types of the serial command port
package scp_pkg;
	localparam int unsigned SCP_CLK_HZ = 50000000;
	localparam int unsigned SCP_BAUD_FAST = 19200;
	localparam int unsigned SCP_BAUD_MID = 9600;
	localparam int unsigned SCP_BAUD_SLOW = 1200;
	localparam int unsigned SCP_OVS = 16;
	// Oversample tick divisors, rounded down
	localparam int unsigned SCP_DIV_FAST = SCP_CLK_HZ / (SCP_BAUD_FAST * SCP_OVS);
	localparam int unsigned SCP_DIV_MID = SCP_CLK_HZ / (SCP_BAUD_MID * SCP_OVS);
	localparam int unsigned SCP_DIV_SLOW = SCP_CLK_HZ / (SCP_BAUD_SLOW * SCP_OVS);
	localparam int unsigned SCP_DATA_BITS = 8;
	localparam int unsigned SCP_FIFO_DEPTH = 8;
	localparam int unsigned SCP_RX_HEADROOM = 2;
	localparam logic SCP_LINE_IDLE = 1'h1;
	localparam logic SCP_CTS_READY = 1'h0;

	typedef struct packed {
		logic jumper_mid;
		logic jumper_slow;
	} scp_jumpers_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} scp_char_t;

	typedef enum logic [3:0] {
		SCP_IDLE = 4'h1,
		SCP_START = 4'h2,
		SCP_DATA = 4'h4,
		SCP_STOP = 4'h8
	} scp_state_t;
endpackage

// ### scp_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module scp_fifo
	import scp_pkg::*;
#(
	parameter int unsigned WIDTH = SCP_DATA_BITS,
	parameter int unsigned DEPTH = SCP_FIFO_DEPTH
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(DEPTH):0] level
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic ready_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Ready is kept in a flop so that a port built on this queue drives it registered
	assign in_ready = ready_reg;
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign level = count_reg;
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'h1;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			ready_reg <= (count_next != (AW+1)'(DEPTH));
		end
	end
endmodule

// ### scp_port.sv
// Serial command port: UART with jumper rate and hardware handshake
`timescale 1ns/1ps
module scp_port
	import scp_pkg::*;
#(
	parameter int unsigned DEPTH = SCP_FIFO_DEPTH
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire scp_jumpers_t jumpers,
	input wire logic rx_line,
	input wire logic rts_line,
	output logic tx_line,
	output logic cts_line,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output scp_char_t rx_char,
	input wire logic rx_ready
);
	localparam int unsigned DW = $clog2(SCP_DIV_SLOW + 1);
	localparam int unsigned LW = $clog2(DEPTH) + 1;

	// Pin synchronisers, jumpers included since they are pins too
	logic [1:0] rx_sync_reg, rts_sync_reg, jm_sync_reg, js_sync_reg;
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rx_sync_reg <= 2'h3;
			rts_sync_reg <= 2'h3;
			jm_sync_reg <= 2'h0;
			js_sync_reg <= 2'h0;
		end
		else
		begin
			rx_sync_reg <= {rx_sync_reg[0], rx_line};
			rts_sync_reg <= {rts_sync_reg[0], rts_line};
			jm_sync_reg <= {jm_sync_reg[0], jumpers.jumper_mid};
			js_sync_reg <= {js_sync_reg[0], jumpers.jumper_slow};
		end
	end
	wire rx_s = rx_sync_reg[1];
	wire host_hold = rts_sync_reg[1];

	// Both jumpers on is undocumented; it falls to the slowest rate
	wire [DW-1:0] div_sel = (!jm_sync_reg[1] && !js_sync_reg[1]) ? DW'(SCP_DIV_FAST) :
		(jm_sync_reg[1] && !js_sync_reg[1]) ? DW'(SCP_DIV_MID) : DW'(SCP_DIV_SLOW);

	// Shared 16x oversample tick
	logic [DW-1:0] div_reg;
	wire tick = (div_reg >= div_sel - 1'b1);
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			div_reg <= '0;
		else
			div_reg <= tick ? '0 : div_reg + 1'b1;
	end

	// Transmitter
	scp_state_t tx_state_reg;
	logic [3:0] tx_ph_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_sh_reg;
	logic [7:0] txf_data;
	logic txf_valid;
	wire tx_end = tick && (tx_ph_reg == 4'hF);
	wire tx_take = (tx_state_reg == SCP_IDLE) && txf_valid && !host_hold;
	wire txf_pop = tx_take;

	scp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(txf_data),
		.out_valid(txf_valid),
		.out_ready(txf_pop),
		.level()
	);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			tx_state_reg <= SCP_IDLE;
			tx_ph_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_sh_reg <= 8'h00;
			tx_line <= SCP_LINE_IDLE;
		end
		else
		begin
			if (tick)
				tx_ph_reg <= tx_ph_reg + 4'h1;
			case (tx_state_reg)
				SCP_IDLE:
				begin
					tx_line <= SCP_LINE_IDLE;
					if (tx_take)
					begin
						tx_sh_reg <= txf_data;
						tx_ph_reg <= 4'h0;
						tx_line <= 1'h0;
						tx_state_reg <= SCP_START;
					end
				end
				SCP_START:
					if (tx_end)
					begin
						tx_line <= tx_sh_reg[0];
						tx_bit_reg <= 3'h0;
						tx_state_reg <= SCP_DATA;
					end
				SCP_DATA:
					if (tx_end)
					begin
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg == 3'h7)
						begin
							tx_line <= SCP_LINE_IDLE;
							tx_state_reg <= SCP_STOP;
						end
						else
							tx_line <= tx_sh_reg[tx_bit_reg + 3'h1];
					end
				SCP_STOP:
					if (tx_end)
						tx_state_reg <= SCP_IDLE;
				default:
					tx_state_reg <= SCP_IDLE;
			endcase
		end
	end

	// Receiver, independent of the transmitter
	scp_state_t rx_state_reg;
	logic [3:0] rx_ph_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_sh_reg;
	logic rxf_push;
	logic [LW-1:0] rxf_level;
	logic rxf_in_ready;
	logic rxf_out_valid;
	logic [7:0] rxf_out_data;
	wire rx_mid = tick && (rx_ph_reg == 4'h7);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rx_state_reg <= SCP_IDLE;
			rx_ph_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_sh_reg <= 8'h00;
			rxf_push <= 1'h0;
		end
		else
		begin
			rxf_push <= 1'h0;
			if (tick)
				rx_ph_reg <= rx_ph_reg + 4'h1;
			case (rx_state_reg)
				SCP_IDLE:
					if (!rx_s)
					begin
						rx_ph_reg <= 4'h0;
						rx_state_reg <= SCP_START;
					end
				SCP_START:
					if (rx_mid)
					begin
						// A glitch that is gone by mid-bit is not a start
						rx_state_reg <= rx_s ? SCP_IDLE : SCP_DATA;
						rx_bit_reg <= 3'h0;
					end
				SCP_DATA:
					if (rx_mid)
					begin
						rx_sh_reg <= {rx_s, rx_sh_reg[7:1]};
						rx_bit_reg <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == 3'h7)
							rx_state_reg <= SCP_STOP;
					end
				SCP_STOP:
					if (rx_mid)
					begin
						// Framing errors are dropped; overflow beyond headroom is lost
						rxf_push <= rx_s && rxf_in_ready;
						rx_state_reg <= SCP_IDLE;
					end
				default:
					rx_state_reg <= SCP_IDLE;
			endcase
		end
	end

	wire rx_take = rx_ready && rx_char.valid;

	scp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_data(rx_sh_reg),
		.in_valid(rxf_push),
		.in_ready(rxf_in_ready),
		.out_data(rxf_out_data),
		.out_valid(rxf_out_valid),
		.out_ready(rx_take),
		.level(rxf_level)
	);

	// Output stage mirrors the FIFO head from a flop
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			rx_char <= '0;
		else
			rx_char <= '{valid: rxf_out_valid && !rx_take,
				data: rxf_out_data};
	end

	// Raised early so a host that sends a character or two late still fits
	wire rx_full_soon = (rxf_level >= LW'(DEPTH - SCP_RX_HEADROOM));
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			cts_line <= SCP_CTS_READY;
		else
			cts_line <= rx_full_soon ? !SCP_CTS_READY : SCP_CTS_READY;
	end

	// Assertions
	sequence tx_begin_s;
		(tx_state_reg == SCP_IDLE) ##1 (tx_state_reg == SCP_START);
	endsequence

	tx_hold_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_begin_s |-> !$past(host_hold, 1))
		else $error("character started while host held request");
	tx_start_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tx_state_reg == SCP_START) |-> !tx_line)
		else $error("start bit not low");
	tx_stop_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tx_state_reg == SCP_STOP) |-> tx_line)
		else $error("stop bit not high");
	tx_idle_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tx_state_reg == SCP_IDLE) && ($past(tx_state_reg) == SCP_IDLE) |-> tx_line)
		else $error("idle line not high");
	cts_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rx_full_soon |=> cts_line)
		else $error("clear-to-send low while receiver full");
	cts_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!rx_full_soon |=> !cts_line)
		else $error("clear-to-send high while receiver has room");
	rate_fast_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!jm_sync_reg[1] && !js_sync_reg[1]) |-> div_sel == DW'(SCP_DIV_FAST))
		else $error("wrong divisor with no jumpers");
	rate_mid_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(jm_sync_reg[1] && !js_sync_reg[1]) |-> div_sel == DW'(SCP_DIV_MID))
		else $error("wrong divisor with first jumper");
	rate_slow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!jm_sync_reg[1] && js_sync_reg[1]) |-> div_sel == DW'(SCP_DIV_SLOW))
		else $error("wrong divisor with second jumper");
	rx_push_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rxf_push |-> ($past(rx_state_reg) == SCP_STOP) && $past(rx_s))
		else $error("character stored without valid stop bit");
endmodule

// ### scp_host.sv
// Behavioural host terminal on the far side of the serial port
`timescale 1ns/1ps
module scp_host
	import scp_pkg::*;
#(
	parameter int BIT_CYC = 16 * SCP_DIV_FAST
)
(
	input wire logic clk_sys,
	input wire logic tx_line,
	input wire logic cts_line,
	output logic rx_line,
	output logic rts_line
);
	initial
	begin
		rx_line = SCP_LINE_IDLE;
		rts_line = 1'h0;
	end

	// Host side of the handshake: high means the host cannot take more
	task automatic set_busy(input logic v);
		@(posedge clk_sys);
		rts_line <= v;
	endtask

	task automatic send_char(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'h1, b, 1'h0};
		while (cts_line !== SCP_CTS_READY)
			@(posedge clk_sys);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_sys);
			rx_line <= frame[i];
			repeat (BIT_CYC - 1) @(posedge clk_sys);
		end
	endtask

	// Samples mid-bit; ok falls if start or stop bit is wrong
	task automatic recv_char(output logic [7:0] b, output logic ok);
		@(negedge tx_line);
		repeat (BIT_CYC / 2) @(posedge clk_sys);
		ok = (tx_line === 1'h0);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(posedge clk_sys);
			b[i] = tx_line;
		end
		repeat (BIT_CYC) @(posedge clk_sys);
		ok = ok && (tx_line === 1'h1);
	endtask
endmodule

// ### tb.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ps
module tb;
	import scp_pkg::*;
	localparam int unsigned DEPTH = 4;
	localparam int BIT_CYC_WAIT = 16 * SCP_DIV_FAST;
	// About 72000 cycles of tests expected; this leaves some margin under the run limit
	localparam int WATCHDOG_CYC = 34 * BIT_CYC_WAIT;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	scp_jumpers_t jumpers = '0;
	logic rx_line;
	logic rts_line;
	logic tx_line;
	logic cts_line;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'h0;
	logic tx_ready;
	scp_char_t rx_char;
	logic rx_ready = 1'h0;
	int err_total = 0;
	int compares = 0;

	always #10 clk_sys = ~clk_sys;

	scp_port #(.DEPTH(DEPTH)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .jumpers(jumpers),
		.rx_line(rx_line), .rts_line(rts_line), .tx_line(tx_line), .cts_line(cts_line),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_char(rx_char),
		.rx_ready(rx_ready));
	scp_host host (.clk_sys(clk_sys), .tx_line(tx_line), .cts_line(cts_line),
		.rx_line(rx_line), .rts_line(rts_line));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors %0d, compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic push(input logic [7:0] b);
		@(posedge clk_sys);
		tx_data <= b;
		tx_valid <= 1'h1;
		do @(negedge clk_sys); while (tx_ready !== 1'h1);
		@(posedge clk_sys);
		tx_valid <= 1'h0;
	endtask

	task automatic do_reset();
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
	endtask

	// Held request must keep the line idle; release lets the frame out
	task automatic test_tx_hold();
		logic [7:0] b;
		logic ok;
		host.set_busy(1'h1);
		repeat (4) @(posedge clk_sys);
		push(8'hA5);
		repeat (300) @(posedge clk_sys);
		check({7'h0, tx_line}, {7'h0, SCP_LINE_IDLE});
		host.set_busy(1'h0);
		host.recv_char(b, ok);
		check(b, 8'hA5);
		check({7'h0, ok}, 8'h01);
	endtask

	// Fill the receive queue to the clear-to-send threshold with the user stalled, then drain it
	task automatic test_rx_full();
		logic [7:0] exp [2];
		exp = '{8'h3C, 8'hC3};
		@(negedge clk_sys);
		check({7'h0, cts_line}, {7'h0, SCP_CTS_READY});
		for (int i = 0; i < DEPTH - SCP_RX_HEADROOM; i++)
			host.send_char(exp[i]);
		repeat (BIT_CYC_WAIT) @(posedge clk_sys);
		check({7'h0, cts_line}, {7'h0, ~SCP_CTS_READY});
		for (int i = 0; i < DEPTH - SCP_RX_HEADROOM; i++)
		begin
			@(posedge clk_sys);
			rx_ready <= 1'h1;
			do @(negedge clk_sys); while (rx_char.valid !== 1'h1);
			check(rx_char.data, exp[i]);
			@(posedge clk_sys);
			rx_ready <= 1'h0;
		end
		repeat (4) @(posedge clk_sys);
		check({7'h0, cts_line}, {7'h0, SCP_CTS_READY});
	endtask

	// Start bit length follows the jumpers; slow rate only checked past mid
	task automatic test_rate();
		int n;
		jumpers <= '{jumper_mid: 1'h1, jumper_slow: 1'h0};
		do_reset();
		push(8'h01);
		@(negedge tx_line);
		n = 0;
		while (tx_line === 1'h0)
		begin
			@(posedge clk_sys);
			n++;
		end
		check({7'h0, n >= 15 * SCP_DIV_MID && n <= 17 * SCP_DIV_MID}, 8'h01);
		jumpers <= '{jumper_mid: 1'h0, jumper_slow: 1'h1};
		do_reset();
		push(8'h01);
		@(negedge tx_line);
		repeat (18 * SCP_DIV_MID) @(posedge clk_sys);
		check({7'h0, tx_line}, 8'h00);
		// Both jumpers on falls to the slowest rate
		jumpers <= '{jumper_mid: 1'h1, jumper_slow: 1'h1};
		do_reset();
		push(8'h01);
		@(negedge tx_line);
		repeat (18 * SCP_DIV_MID) @(posedge clk_sys);
		check({7'h0, tx_line}, 8'h00);
	endtask

	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
		fork
			test_tx_hold();
			test_rx_full();
		join
		test_rate();
		finish_test();
	end

	initial
	begin
		repeat (WATCHDOG_CYC) @(posedge clk_sys);
		err_total++;
		finish_test();
	end
endmodule
